// file: pds_host_model.sv
// Host model: drives the supply comparator and the run request
module pds_host_model (
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  input  wire logic [1:0] cmd_i,
  output logic            main_supply_low_o,
  output logic            projector_on_request_o,
  output logic            supplies_ok_o,
  output logic            sequencer_clock_in_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] hold_ff;
  logic        fired_ff;
  // Bit 0 trips the supply, bit 1 drops the request
  assign main_supply_low_o      = cmd_i[0];
  assign projector_on_request_o = ~cmd_i[1];
  // Nominal rate, no spread; the block times itself from its own tick
  initial begin
    sequencer_clock_in_o = 1'b0;
    forever #16.667 sequencer_clock_in_o = ~sequencer_clock_in_o;
  end
  // Rails held in range only for the window owed, then lost
  assign supplies_ok_o = !fired_ff || (hold_ff != 16'h0000);
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hold_ff  <= 16'h0000;
      fired_ff <= 1'b0;
    end else if (!fired_ff && cmd_i != 2'h0) begin
      fired_ff <= 1'b1;
      // Supply trip wins, so its shorter hold window applies
      hold_ff  <= cmd_i[0] ? 16'h2328 : 16'h4588;
    end else if (hold_ff != 16'h0000) begin
      hold_ff <= hold_ff - 16'h0001;
    end
  end
endmodule : pds_host_model

// file: pds_pkg.sv
// Constants for the power-down sequencer
package pds_pkg;
  localparam int CLK_KHZ          = 10_000;
  localparam int OSC_KHZ          = 2_000;
  localparam int OSC_DIV          = CLK_KHZ / OSC_KHZ;
  localparam int CYC_PER_US       = CLK_KHZ / 1_000;
  localparam int TICK_PER_US      = OSC_KHZ / 1_000;
  // Timing limits in microseconds; TICK_MARGIN is in oscillator ticks
  localparam int T_TRIP_MIN_US    = 52;
  localparam int T_TRIP_MAX_US    = 120;
  localparam int T_PROJ_MAX_US    = 1_000;
  localparam int T_PROJ_FILT_US   = 20;
  localparam int T_PARK_MAX_US    = 280;
  localparam int T_DISCH_MAX_US   = 260;
  localparam int T_RST_MAX_US     = 500;
  localparam int TICK_MARGIN      = 8;
  // Interval lengths in oscillator ticks; margin covers first-tick phase
  localparam logic [9:0] TRIP_TICKS  = 10'(T_TRIP_MIN_US * TICK_PER_US + 2);
  localparam logic [9:0] PROJ_TICKS  = 10'(T_PROJ_FILT_US * TICK_PER_US);
  localparam logic [9:0] PARK_TICKS  = 10'(T_PARK_MAX_US * TICK_PER_US - TICK_MARGIN);
  localparam logic [9:0] DISCH_TICKS = 10'(T_DISCH_MAX_US * TICK_PER_US - TICK_MARGIN);
  localparam logic [9:0] ZERO_TICKS  = 10'h000;
  localparam logic [2:0] DIV_LAST    = 3'(OSC_DIV - 1);
  localparam logic [2:0] DIV_ZERO    = 3'h0;
  typedef enum logic [2:0] {
    PDS_IDLE  = 3'h0,
    PDS_WAIT  = 3'h1,
    PDS_PARK  = 3'h3,
    PDS_DISCH = 3'h2,
    PDS_DONE  = 3'h6
  } pds_state_t;
endpackage : pds_pkg

// file: pds_sequencer.sv
// Power-down sequencer: park, rail discharge, system reset
// What this block does
// - Main supply below trip threshold starts power-down by itself.
// - Projector-on request low is a second independent power-down trigger.
// - Park output falls 52 to 120 us after a main supply trip.
// - Park output falls within 1 ms after projector-on request goes low.
// - Offset rail discharge starts within 280 us of park falling.
// - Bias, offset and reset rails disabled and discharged within 260 us.
// - System reset falls within 500 us of discharge start.
module pds_sequencer (
  input  wire logic mclk_i,
  input  wire logic rst_b_i,
  input  wire logic main_supply_low_i,
  input  wire logic projector_on_request_i,
  output logic      mirror_park_n_o,
  output logic      bias_rail_en_o,
  output logic      offset_rail_en_o,
  output logic      mirror_reset_rail_en_o,
  output logic      rail_discharge_o,
  output logic      system_reset_n_o,
  output logic      pd_busy_o
);
  pds_pkg::pds_state_t state_ff;
  pds_pkg::pds_state_t nxt_state;
  logic [9:0]          cnt_ff;
  logic [9:0]          nxt_cnt;
  logic                src_proj_ff;
  logic                nxt_src_proj;
  logic                park_n_ff;
  logic                nxt_park_n;
  logic                rails_en_ff;
  logic                nxt_rails_en;
  logic                disch_ff;
  logic                nxt_disch;
  logic                sys_rst_n_ff;
  logic                nxt_sys_rst_n;
  logic                busy_ff;
  logic                nxt_busy;
  logic                tick;

  pds_tick_gen u_tick (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .tick_o  (tick)
  );

  always_comb begin
    nxt_state    = state_ff;
    nxt_cnt      = cnt_ff;
    nxt_src_proj = src_proj_ff;
    if (tick && cnt_ff != pds_pkg::ZERO_TICKS) begin
      nxt_cnt = cnt_ff - 10'h001;
    end
    unique case (state_ff)
      pds_pkg::PDS_IDLE: begin
        if (main_supply_low_i) begin
          nxt_state    = pds_pkg::PDS_WAIT;
          nxt_cnt      = pds_pkg::TRIP_TICKS;
          nxt_src_proj = 1'b0;
        end else if (!projector_on_request_i) begin
          nxt_state    = pds_pkg::PDS_WAIT;
          nxt_cnt      = pds_pkg::PROJ_TICKS;
          nxt_src_proj = 1'b1;
        end
      end
      pds_pkg::PDS_WAIT: begin
        // Trigger clearing now has no effect
        if (cnt_ff == pds_pkg::ZERO_TICKS) begin
          nxt_state = pds_pkg::PDS_PARK;
          nxt_cnt   = pds_pkg::PARK_TICKS;
        end
      end
      pds_pkg::PDS_PARK: begin
        if (cnt_ff == pds_pkg::ZERO_TICKS) begin
          nxt_state = pds_pkg::PDS_DISCH;
          nxt_cnt   = pds_pkg::DISCH_TICKS;
        end
      end
      pds_pkg::PDS_DISCH: begin
        if (cnt_ff == pds_pkg::ZERO_TICKS) begin
          nxt_state = pds_pkg::PDS_DONE;
        end
      end
      pds_pkg::PDS_DONE: begin
        nxt_state = pds_pkg::PDS_DONE;
      end
      default: begin
        nxt_state = pds_pkg::PDS_DONE;
      end
    endcase
  end

  // Outputs follow the next state so each comes straight from a flop
  always_comb begin
    nxt_park_n    = (nxt_state == pds_pkg::PDS_IDLE) || (nxt_state == pds_pkg::PDS_WAIT);
    nxt_rails_en  = nxt_park_n || (nxt_state == pds_pkg::PDS_PARK);
    nxt_disch     = !nxt_rails_en;
    nxt_sys_rst_n = (nxt_state != pds_pkg::PDS_DONE);
    nxt_busy      = (nxt_state != pds_pkg::PDS_IDLE);
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff     <= pds_pkg::PDS_IDLE;
      cnt_ff       <= pds_pkg::ZERO_TICKS;
      src_proj_ff  <= 1'b0;
      park_n_ff    <= 1'b1;
      rails_en_ff  <= 1'b1;
      disch_ff     <= 1'b0;
      sys_rst_n_ff <= 1'b1;
      busy_ff      <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      cnt_ff       <= nxt_cnt;
      src_proj_ff  <= nxt_src_proj;
      park_n_ff    <= nxt_park_n;
      rails_en_ff  <= nxt_rails_en;
      disch_ff     <= nxt_disch;
      sys_rst_n_ff <= nxt_sys_rst_n;
      busy_ff      <= nxt_busy;
    end
  end

  assign mirror_park_n_o        = park_n_ff;
  assign bias_rail_en_o         = rails_en_ff;
  assign offset_rail_en_o       = rails_en_ff;
  assign mirror_reset_rail_en_o = rails_en_ff;
  assign rail_discharge_o       = disch_ff;
  assign system_reset_n_o       = sys_rst_n_ff;
  assign pd_busy_o              = busy_ff;

  // Helper: cycles spent in the current state
  logic [15:0] st_cyc_ff;
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_cyc_ff <= 16'h0000;
    end else if (nxt_state != state_ff) begin
      st_cyc_ff <= 16'h0000;
    end else if (st_cyc_ff != 16'hFFFF) begin
      st_cyc_ff <= st_cyc_ff + 16'h0001;
    end
  end

  int trip_min_cyc;
  int trip_max_cyc;
  int proj_max_cyc;
  int park_max_cyc;
  int disch_max_cyc;
  int rst_max_cyc;
  assign trip_min_cyc  = pds_pkg::T_TRIP_MIN_US * pds_pkg::CYC_PER_US;
  assign trip_max_cyc  = pds_pkg::T_TRIP_MAX_US * pds_pkg::CYC_PER_US;
  assign proj_max_cyc  = pds_pkg::T_PROJ_MAX_US * pds_pkg::CYC_PER_US;
  assign park_max_cyc  = pds_pkg::T_PARK_MAX_US * pds_pkg::CYC_PER_US;
  assign disch_max_cyc = pds_pkg::T_DISCH_MAX_US * pds_pkg::CYC_PER_US;
  assign rst_max_cyc   = pds_pkg::T_RST_MAX_US * pds_pkg::CYC_PER_US;

  sequence s_park_falls;
    $fell(park_n_ff);
  endsequence

  property p_supply_start;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (state_ff == pds_pkg::PDS_IDLE) && main_supply_low_i
      |=> (state_ff == pds_pkg::PDS_WAIT) && !src_proj_ff && busy_ff;
  endproperty
  a_supply_start: assert property (p_supply_start) else $error("trip ignored");

  property p_proj_start;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (state_ff == pds_pkg::PDS_IDLE) && !projector_on_request_i && !main_supply_low_i
      |=> (state_ff == pds_pkg::PDS_WAIT) && src_proj_ff;
  endproperty
  a_proj_start: assert property (p_proj_start) else $error("request ignored");

  property p_trip_park;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (state_ff == pds_pkg::PDS_WAIT) && (nxt_state == pds_pkg::PDS_PARK) && !src_proj_ff
      |-> (st_cyc_ff >= trip_min_cyc - 1) && (st_cyc_ff < trip_max_cyc - 1) ##1 s_park_falls;
  endproperty
  a_trip_park: assert property (p_trip_park) else $error("park timing on trip");

  property p_proj_park;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (state_ff == pds_pkg::PDS_WAIT) && src_proj_ff |-> st_cyc_ff < proj_max_cyc - 1;
  endproperty
  a_proj_park: assert property (p_proj_park) else $error("park late on request");

  sequence s_disch_starts;
    $rose(disch_ff);
  endsequence

  // Park must lead the rail cut, never share its edge
  property p_park_to_disch;
    @(posedge mclk_i) disable iff (!rst_b_i)
    s_disch_starts |-> !park_n_ff && !rails_en_ff && !$past(park_n_ff, 2);
  endproperty
  a_park_to_disch: assert property (p_park_to_disch) else $error("rails off before park");

  property p_park_len;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (state_ff == pds_pkg::PDS_PARK) |-> st_cyc_ff < park_max_cyc - 1;
  endproperty
  a_park_len: assert property (p_park_len) else $error("park too long");

  property p_disch_len;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (state_ff == pds_pkg::PDS_DISCH) |-> disch_ff && !rails_en_ff && st_cyc_ff < disch_max_cyc;
  endproperty
  a_disch_len: assert property (p_disch_len) else $error("discharge too long");

  property p_reset_after_disch;
    @(posedge mclk_i) disable iff (!rst_b_i)
    disch_ff && sys_rst_n_ff |-> st_cyc_ff < rst_max_cyc - 1;
  endproperty
  a_reset_after_disch: assert property (p_reset_after_disch) else $error("reset late");

  property p_done_holds;
    @(posedge mclk_i) disable iff (!rst_b_i)
    !sys_rst_n_ff |=> !sys_rst_n_ff && disch_ff && !park_n_ff;
  endproperty
  a_done_holds: assert property (p_done_holds) else $error("reset released");

  property p_no_abort;
    @(posedge mclk_i) disable iff (!rst_b_i)
    busy_ff |=> busy_ff;
  endproperty
  a_no_abort: assert property (p_no_abort) else $error("sequence aborted");

  // Count moves on the edge that samples a tick, seen one edge later
  property p_count_on_tick;
    @(posedge mclk_i) disable iff (!rst_b_i)
    !$past(tick) && (state_ff == $past(state_ff)) && (state_ff != pds_pkg::PDS_IDLE)
      |-> cnt_ff == $past(cnt_ff);
  endproperty
  a_count_on_tick: assert property (p_count_on_tick) else $error("count off tick");
endmodule : pds_sequencer

// file: pds_tick_gen.sv
// Oscillator-rate tick divider
module pds_tick_gen (
  input  wire logic mclk_i,
  input  wire logic rst_b_i,
  output logic      tick_o
);
  logic [2:0] div_ff;
  logic [2:0] nxt_div;
  logic       tick_ff;
  logic       nxt_tick;

  always_comb begin
    nxt_div  = (div_ff == pds_pkg::DIV_LAST) ? pds_pkg::DIV_ZERO : div_ff + 3'h1;
    nxt_tick = (div_ff == pds_pkg::DIV_LAST);
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_ff  <= pds_pkg::DIV_ZERO;
      tick_ff <= 1'b0;
    end else begin
      div_ff  <= nxt_div;
      tick_ff <= nxt_tick;
    end
  end

  assign tick_o = tick_ff;

  property p_tick_spacing;
    @(posedge mclk_i) disable iff (!rst_b_i)
    tick_ff |=> !tick_ff [*4] ##1 tick_ff;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("tick spacing wrong");
endmodule : pds_tick_gen

// file: tb.sv
// Self-checking bench for the power-down sequencer
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk_i  = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [1:0]  cmd     = 2'h0;
  logic        supply_low;
  logic        run_req;
  logic        park_n;
  logic        bias_en;
  logic        offset_en;
  logic        reset_rail_en;
  logic        discharge;
  logic        system_reset_n;
  logic        busy;
  logic        supplies_ok;
  logic [16:0] seed    = 17'h1_7cec;
  int          fails   = 0;
  int          samples_checked = 0;
  int          cycles  = 0;

  initial begin
    forever #50 mclk_i = ~mclk_i;
  end

  pds_host_model pds_host_model_inst (
    .mclk_i                 (mclk_i),
    .rst_b_i                (rst_b_i),
    .cmd_i                  (cmd),
    .main_supply_low_o      (supply_low),
    .projector_on_request_o (run_req),
    .supplies_ok_o          (supplies_ok),
    .sequencer_clock_in_o   ()
  );

  pds_sequencer pds_sequencer_inst (
    .mclk_i                 (mclk_i),
    .rst_b_i                (rst_b_i),
    .main_supply_low_i      (supply_low),
    .projector_on_request_i (run_req),
    .mirror_park_n_o        (park_n),
    .bias_rail_en_o         (bias_en),
    .offset_rail_en_o       (offset_en),
    .mirror_reset_rail_en_o (reset_rail_en),
    .rail_discharge_o       (discharge),
    .system_reset_n_o       (system_reset_n),
    .pd_busy_o              (busy)
  );

  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : lfsr

  // Supply trip wins when both triggers coincide
  function automatic int park_min(input logic [1:0] mode);
    return mode[0] ? 520 : 0;
  endfunction : park_min

  function automatic int park_max(input logic [1:0] mode);
    return mode[0] ? 1200 : 10000;
  endfunction : park_max

  function automatic logic pick(input int which);
    case (which)
      0: return park_n;
      1: return discharge;
      default: return system_reset_n;
    endcase
  endfunction : pick

  task automatic check(input logic seen, input logic exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %b, wanted %b", $time, seen, exp);
    end
  endtask : check

  task automatic summarize;
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  // Bounded wait; the count is judged by the caller
  task automatic wait_out(input int which, input logic lvl, output int n);
    n = 0;
    while (pick(which) !== lvl && n < 20000) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
  endtask : wait_out

  task automatic run_seq(input logic [1:0] mode);
    int n;
    @(negedge mclk_i);
    rst_b_i = 1'b0;
    cmd     = 2'h0;
    repeat (2) @(negedge mclk_i);
    check(park_n & bias_en & offset_en & reset_rail_en, 1'b1);
    check(discharge | busy, 1'b0);
    check(system_reset_n, 1'b1);
    rst_b_i = 1'b1;
    repeat (int'(seed[5:0]) + 2) begin
      @(negedge mclk_i);
      check(busy | ~park_n, 1'b0);
    end
    cmd = mode;
    wait_out(0, 1'b0, n);
    check(n >= park_min(mode) && n <= park_max(mode), 1'b1);
    @(negedge mclk_i);
    // Trigger cleared mid-sequence must not stop it
    cmd = 2'h0;
    check(busy, 1'b1);
    wait_out(1, 1'b1, n);
    check(n <= 2800, 1'b1);
    check(bias_en | offset_en | reset_rail_en, 1'b0);
    wait_out(2, 1'b0, n);
    check(n <= 5000, 1'b1);
    check(supplies_ok, 1'b1);
    repeat (30) @(negedge mclk_i);
    check(system_reset_n | park_n, 1'b0);
    check(discharge & busy, 1'b1);
  endtask : run_seq

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      summarize();
    end
  end

  // Fixed corner modes first, then drawn ones
  initial begin
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      if (i < 3) begin
        run_seq(2'(i + 1));
      end else begin
        run_seq(seed[7:6] == 2'h0 ? 2'h2 : seed[7:6]);
      end
    end
    summarize();
  end
endmodule : tb
